// ===== logic/rops_pkg.sv
package rops_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SEL_W = 6;
  localparam int unsigned NUM_REGS = 6;
  localparam int unsigned NUM_PINS = 12;
  localparam int unsigned FIRST_PIN = 14;
  localparam int unsigned NUM_FUNCS = 64;
  localparam logic [ADDR_W-1:0] OUTPUT_SELECT_PINS_14_15 = 3'h0;
  localparam logic [ADDR_W-1:0] OUTPUT_SELECT_PINS_16_17 = 3'h1;
  localparam logic [ADDR_W-1:0] OUTPUT_SELECT_PINS_18_19 = 3'h2;
  localparam logic [ADDR_W-1:0] OUTPUT_SELECT_PINS_20_21 = 3'h3;
  localparam logic [ADDR_W-1:0] OUTPUT_SELECT_PINS_22_23 = 3'h4;
  localparam logic [ADDR_W-1:0] OUTPUT_SELECT_PINS_24_25 = 3'h5;

  // ****************************************************************
  // Field layout and reset
  // ****************************************************************
  localparam int unsigned EVEN_LSB = 0;
  localparam int unsigned ODD_LSB = 8;
  localparam logic [SEL_W-1:0] SEL_RESET = 6'h00;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 16'h0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [SEL_W-1:0] rops_sel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rops_bus_s;

endpackage

// ===== logic/rops_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none

module rops_pin_mux (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic [rops_pkg::SEL_W-1:0] i_select,
  input wire logic [rops_pkg::NUM_FUNCS-1:0] i_functions,
  output logic o_pin
);

  logic pin_r;
  logic pin_nxt;

  // ****************************************************************
  // Function select
  // ****************************************************************
  always_comb begin
    pin_nxt = i_enable ? i_functions[i_select] : 1'b0; // R1 R7
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign o_pin = pin_r;

  a_pin_follows_sel: assert property (@(posedge i_clock) disable iff (i_reset) // R1
    ##1 !$past(i_reset) |-> o_pin == ($past(i_enable) && $past(i_functions[i_select])))
    else $error("Pin does not follow selected function");

endmodule

`default_nettype wire

// ===== logic/rops_output_select.sv
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1: Each selector value picks the peripheral function number driving its pin.
// R2: Bits 13..8 of each register select the odd pin of the pair.
// R3: Bits 5..0 select the even pin; registers cover pins 14..25 in order.
// R4: Bits 15..14 and 7..6 read zero and ignore writes.
// R5: Implemented selector bits are read/write and clear to zero at reset.
// R6: Reduced variant omits the pin 15 selector at build time.
// R7: An absent selector reads zero, ignores writes, and drives no pin.
module rops_output_select #(
  parameter bit HAS_PIN15 = 1'b1
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [rops_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rops_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [rops_pkg::DATA_W-1:0] o_rdata,
  input wire logic [rops_pkg::NUM_FUNCS-1:0] i_functions,
  output logic [rops_pkg::NUM_PINS-1:0] o_pins
);

  // ****************************************************************
  // Selector state
  // ****************************************************************
  rops_pkg::rops_bus_s bus;
  rops_pkg::rops_sel_t sel_r [rops_pkg::NUM_PINS];
  rops_pkg::rops_sel_t sel_nxt [rops_pkg::NUM_PINS];
  logic [rops_pkg::DATA_W-1:0] rdata_r;
  logic [rops_pkg::DATA_W-1:0] rdata_nxt;
  logic [rops_pkg::NUM_PINS-1:0] present;
  // Flat copy lets the checks compare every selector in one expression
  logic [rops_pkg::NUM_PINS*rops_pkg::SEL_W-1:0] sel_flat;

  assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  // Pin index 1 is pin 15; only that one can be left out of a build
  function automatic logic pin_present(input int unsigned idx);
    return !(idx == 1 && !HAS_PIN15); // R6
  endfunction

  // Field slice of a register word for a pin index
  function automatic rops_pkg::rops_sel_t field_of(input logic [rops_pkg::DATA_W-1:0] w, input int unsigned idx);
    return (idx % 2 == 1) ? w[rops_pkg::ODD_LSB +: rops_pkg::SEL_W] // R2
                          : w[rops_pkg::EVEN_LSB +: rops_pkg::SEL_W]; // R3
  endfunction

  always_comb begin
    for (int unsigned i = 0; i < rops_pkg::NUM_PINS; i++) begin
      present[i] = pin_present(i);
      sel_nxt[i] = sel_r[i];
      if (bus.wr && bus.addr == rops_pkg::ADDR_W'(i / 2) && present[i]) begin
        sel_nxt[i] = field_of(bus.wdata, i); // R5 R4 R7
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rdata_nxt = rops_pkg::RDATA_IDLE; // R4
    if (bus.rd) begin
      for (int unsigned i = 0; i < rops_pkg::NUM_PINS; i++) begin
        if (bus.addr == rops_pkg::ADDR_W'(i / 2) && present[i]) begin
          if (i % 2 == 1) begin
            rdata_nxt[rops_pkg::ODD_LSB +: rops_pkg::SEL_W] = sel_r[i]; // R2
          end else begin
            rdata_nxt[rops_pkg::EVEN_LSB +: rops_pkg::SEL_W] = sel_r[i]; // R3
          end
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      for (int unsigned i = 0; i < rops_pkg::NUM_PINS; i++) begin
        sel_r[i] <= rops_pkg::SEL_RESET; // R5
      end
      rdata_r <= rops_pkg::RDATA_IDLE;
    end else begin
      for (int unsigned i = 0; i < rops_pkg::NUM_PINS; i++) begin
        sel_r[i] <= sel_nxt[i];
      end
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;

  // ****************************************************************
  // Pin multiplexers
  // ****************************************************************
  // Registered pins add one cycle of latency but keep outputs glitch free
  genvar g;
  generate
    for (g = 0; g < rops_pkg::NUM_PINS; g++) begin : g_pin
      assign sel_flat[g*rops_pkg::SEL_W +: rops_pkg::SEL_W] = sel_r[g];
      rops_pin_mux u_mux (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_enable(present[g]), // R7
        .i_select(sel_r[g]),
        .i_functions(i_functions),
        .o_pin(o_pins[g]) // R1
      );
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_reserved_zero: assert property (@(posedge i_clock) disable iff (i_reset) // R4
    o_rdata[15:14] == 2'h0 && o_rdata[7:6] == 2'h0)
    else $error("Reserved bits read nonzero");

  a_write_read_even: assert property (@(posedge i_clock) disable iff (i_reset) // R3
    i_wr && i_addr == 3'h2 ##1 i_rd && i_addr == 3'h2 |=> o_rdata[5:0] == $past(i_wdata[5:0], 2))
    else $error("Even field readback mismatch");

  a_write_read_odd: assert property (@(posedge i_clock) disable iff (i_reset) // R2
    i_wr && i_addr == 3'h5 ##1 i_rd && i_addr == 3'h5 |=> o_rdata[13:8] == $past(i_wdata[13:8], 2))
    else $error("Odd field readback mismatch");

  a_reset_clears: assert property (@(posedge i_clock) // R5
    i_reset |=> sel_r[0] == 6'h00 && sel_r[11] == 6'h00)
    else $error("Selector not cleared by reset");

  a_pins_reset_zero: assert property (@(posedge i_clock) // R5
    i_reset |=> o_pins == 12'h000)
    else $error("Pins not low after reset");

  a_rdata_reset_zero: assert property (@(posedge i_clock) // R5
    i_reset |=> o_rdata == 16'h0000)
    else $error("Read data not zero after reset");

  a_pin15_absent: assert property (@(posedge i_clock) disable iff (i_reset) // R6
    !HAS_PIN15 |-> sel_r[1] == 6'h00 && o_pins[1] == 1'b0)
    else $error("Absent pin 15 selector active");

  a_idle_read_zero: assert property (@(posedge i_clock) disable iff (i_reset) // R7
    !i_rd |=> o_rdata == 16'h0000)
    else $error("Read data outside read cycle");

  a_pin_routes: assert property (@(posedge i_clock) disable iff (i_reset) // R1
    ##2 !$past(i_reset) && !$past(i_reset, 2) |-> o_pins[0] == $past(i_functions[sel_r[0]]))
    else $error("Pin 14 not routed from selected function");

  a_unmapped_zero: assert property (@(posedge i_clock) disable iff (i_reset) // R4
    i_rd && i_addr > 3'h5 |=> o_rdata == 16'h0000)
    else $error("Unmapped address returned data");

  // ****************************************************************
  // Checks on selector storage and absent pin 15 readback
  // ****************************************************************
  // Most checks here watch a few fixed registers; a_unmapped_write and a_no_write_hold cover every selector
  a_unmapped_write: assert property (@(posedge i_clock) disable iff (i_reset) // R4
    i_wr && i_addr > 3'h5 |=> sel_flat == $past(sel_flat))
    else $error("Unmapped write changed a selector");

  a_no_write_hold: assert property (@(posedge i_clock) disable iff (i_reset) // R5
    !i_wr |=> sel_flat == $past(sel_flat))
    else $error("Selector changed without a write");

  a_other_reg_kept: assert property (@(posedge i_clock) disable iff (i_reset) // R5
    i_wr && i_addr == 3'h1 |=> sel_r[0] == $past(sel_r[0]))
    else $error("Write disturbed another register");

  a_write_even_lands: assert property (@(posedge i_clock) disable iff (i_reset) // R3
    i_wr && i_addr == 3'h0 |=> sel_r[0] == $past(i_wdata[5:0]))
    else $error("Pin 14 selector write lost");

  a_write_odd_lands: assert property (@(posedge i_clock) disable iff (i_reset) // R2
    i_wr && i_addr == 3'h3 |=> sel_r[7] == $past(i_wdata[13:8]))
    else $error("Pin 21 selector write lost");

  a_write_pair_split: assert property (@(posedge i_clock) disable iff (i_reset) // R2
    i_wr && i_addr == 3'h2 |=> sel_r[4] == $past(i_wdata[5:0]) && sel_r[5] == $past(i_wdata[13:8]))
    else $error("Pins 18 and 19 selectors swapped");

  a_write_last_odd: assert property (@(posedge i_clock) disable iff (i_reset) // R3
    i_wr && i_addr == 3'h5 |=> sel_r[10] == $past(i_wdata[5:0]) && sel_r[11] == $past(i_wdata[13:8]))
    else $error("Pins 24 and 25 selectors write lost");

  a_pin15_present: assert property (@(posedge i_clock) disable iff (i_reset) // R6
    HAS_PIN15 && i_wr && i_addr == 3'h0 |=> sel_r[1] == $past(i_wdata[13:8]))
    else $error("Pin 15 selector write lost");

  a_pin15_read_zero: assert property (@(posedge i_clock) disable iff (i_reset) // R7
    !HAS_PIN15 && i_rd && i_addr == 3'h0 |=> o_rdata[13:8] == 6'h00)
    else $error("Absent pin 15 selector read nonzero");

  // ****************************************************************
  // Checks on read data and pins
  // ****************************************************************
  a_read_even_live: assert property (@(posedge i_clock) disable iff (i_reset) // R3
    i_rd && i_addr == 3'h1 |=> o_rdata[5:0] == $past(sel_r[2]))
    else $error("Pin 16 selector read mismatch");

  a_read_odd_live: assert property (@(posedge i_clock) disable iff (i_reset) // R2
    i_rd && i_addr == 3'h4 |=> o_rdata[13:8] == $past(sel_r[9]))
    else $error("Pin 23 selector read mismatch");

  a_pin_routes_mid: assert property (@(posedge i_clock) disable iff (i_reset) // R1
    ##2 !$past(i_reset) && !$past(i_reset, 2) |-> o_pins[5] == $past(i_functions[sel_r[5]]))
    else $error("Pin 19 not routed from selected function");

  a_pin_routes_last: assert property (@(posedge i_clock) disable iff (i_reset) // R1
    ##2 !$past(i_reset) && !$past(i_reset, 2) |-> o_pins[11] == $past(i_functions[sel_r[11]]))
    else $error("Pin 25 not routed from selected function");

endmodule

`default_nettype wire

// ===== test/rops_periph_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Peripheral outputs: one function high at a time
// ****************************************************************
module rops_periph_model (
  input wire logic i_clock,
  input wire logic [rops_pkg::SEL_W-1:0] i_active,
  output logic [rops_pkg::NUM_FUNCS-1:0] o_functions
);
  // Registered, so pins see a new function one edge late, as real peripherals would
  always_ff @(posedge i_clock) begin
    o_functions <= 64'h1 << i_active;
  end
endmodule
`default_nettype wire

// ===== test/tb_remappable_output_pin_select.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; $display("mismatch %s expected %h seen %h", n, e, s); end end

module tb_remappable_output_pin_select;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic [rops_pkg::ADDR_W-1:0] addr = 3'h0;
  logic [rops_pkg::DATA_W-1:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [rops_pkg::SEL_W-1:0] active = 6'h3f;
  wire logic [rops_pkg::NUM_FUNCS-1:0] functions;
  wire logic [rops_pkg::DATA_W-1:0] rdata;
  wire logic [rops_pkg::DATA_W-1:0] rdata_s;
  wire logic [rops_pkg::NUM_PINS-1:0] pins;
  wire logic [rops_pkg::NUM_PINS-1:0] pins_s;
  logic [rops_pkg::DATA_W-1:0] got;
  logic [rops_pkg::DATA_W-1:0] got_s;
  int n_mismatch = 0;
  int checked = 0;

  rops_periph_model rops_periph_model_inst (.i_clock(i_clock), .i_active(active), .o_functions(functions));
  rops_output_select rops_output_select_inst (.i_clock(i_clock), .i_reset(i_reset), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_functions(functions), .o_pins(pins));
  // Reduced variant shares the bus, so both see every write; only the full one stores the pin 15 field
  rops_output_select #(.HAS_PIN15(1'b0)) rops_output_select_reduced_inst (.i_clock(i_clock), .i_reset(i_reset),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata_s), .i_functions(functions), .o_pins(pins_s));

  initial begin
    forever #20 i_clock = ~i_clock;
  end

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clock);
  endtask

  task automatic rd_reg(input logic [2:0] a);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
    @(posedge i_clock);
    got = rdata;
    got_s = rdata_s;
  endtask

  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      rd_reg(3'(i));
      `CHK("reset read", 16'h0000, got)
    end
    `CHK("reset pins", 12'h000, pins)
    $display("test reset done");
  endtask

  task automatic t_fields;
    for (int i = 0; i < 8; i++) begin
      wr_reg(3'(i), 16'hffff);
      rd_reg(3'(i));
      `CHK("field mask", (i < 6) ? 16'h3f3f : 16'h0000, got)
      `CHK("reduced mask", (i == 0) ? 16'h003f : ((i < 6) ? 16'h3f3f : 16'h0000), got_s)
    end
    $display("test fields done");
  endtask

  task automatic t_route;
    // Pin 14+k selects function 30+k: distinct numbers expose swapped fields
    for (int r = 0; r < 6; r++) begin
      wr_reg(3'(r), {2'b00, 6'(31 + 2 * r), 2'b00, 6'(30 + 2 * r)});
    end
    wr <= 1'b0;
    for (int k = 0; k < 12; k++) begin
      @(posedge i_clock);
      active <= 6'(30 + k);
      repeat (3) @(posedge i_clock);
      #1;
      `CHK("pin route", 12'h001 << k, pins)
      `CHK("reduced route", (k == 1) ? 12'h000 : (12'h001 << k), pins_s)
    end
    $display("test route done");
  endtask

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge i_clock);
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    t_reset();
    t_fields();
    t_route();
    test_done();
  end
endmodule
`default_nettype wire
